// [verilog/ttgic_map.vh]
// register addresses, field positions and reset values of the tick timer / gpio control block
`ifndef TTGIC_MAP_VH
`define TTGIC_MAP_VH

// byte addresses on the local bus
`define TTGIC_ADDR_T2_CTL 32'hFFF42016
`define TTGIC_ADDR_T1_CTL 32'hFFF42017
`define TTGIC_ADDR_GPIO_ICTL 32'hFFF42018
`define TTGIC_ADDR_GPIO_PIN 32'hFFF42019
`define TTGIC_ADDR_T2_ICTL 32'hFFF4201A
`define TTGIC_ADDR_T1_ICTL 32'hFFF4201B

// timer control register fields
`define TTGIC_CTL_COUNT_ENABLE 0
`define TTGIC_CTL_COMPARE_CLEAR 1
`define TTGIC_CTL_OVERFLOW_CLEAR 2
`define TTGIC_CTL_OVF_LSB 4
`define TTGIC_CTL_OVF_MSB 7

// interrupt control register fields (timers and gpio)
`define TTGIC_ICTL_LEVEL_LSB 0
`define TTGIC_ICTL_LEVEL_MSB 2
`define TTGIC_ICTL_IRQ_CLEAR 3
`define TTGIC_ICTL_IRQ_ENABLE 4
`define TTGIC_ICTL_STATUS 5
`define TTGIC_ICTL_EDGE_MODE 6
`define TTGIC_ICTL_POLARITY 7

// gpio pin control register fields
`define TTGIC_PIN_OUTPUT_VALUE 0
`define TTGIC_PIN_OUTPUT_ENABLE 1
`define TTGIC_PIN_INPUT_VALUE 2

// reset values
`define TTGIC_RESET_BYTE 8'h00
`define TTGIC_RESET_LEVEL 3'h0
`define TTGIC_RESET_OVF 4'h0

`endif

// [verilog/ttgic_timer.v]
// control and interrupt control of one tick timer
`timescale 1ns/1ps
`default_nettype none
`include "ttgic_map.vh"

module ttgic_timer (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register writes, decoded by the parent
    input wire ctl_wr,
    input wire ictl_wr,
    input wire [7:0] wdata,
    // from the prescaler and comparator
    input wire tick,
    input wire match,
    // to the counter
    output wire count_advance,
    output wire count_clear,
    // register read views
    output wire [7:0] ctl_rdata,
    output wire [7:0] ictl_rdata,
    // interrupt request
    output wire irq_req,
    output wire [2:0] irq_level
);

    reg count_enable_reg;
    reg compare_clear_reg;
    reg [3:0] overflow_count_reg;
    reg [2:0] irq_level_reg;
    reg irq_enable_reg;
    reg irq_status_reg;

    // control fields, overflow count and latched status
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_enable_reg <= 1'b0;
            compare_clear_reg <= 1'b0;
            overflow_count_reg <= `TTGIC_RESET_OVF;
            irq_level_reg <= `TTGIC_RESET_LEVEL;
            irq_enable_reg <= 1'b0;
            irq_status_reg <= 1'b0;
        end else begin
            if (ctl_wr) begin
                count_enable_reg <= wdata[`TTGIC_CTL_COUNT_ENABLE]; // RL3
                compare_clear_reg <= wdata[`TTGIC_CTL_COMPARE_CLEAR]; // RL4
            end
            // a match in the clearing cycle still counts, so no event is lost
            if (match) begin
                overflow_count_reg <= overflow_count_reg + 4'h1; // RL1
            end else if (ctl_wr && wdata[`TTGIC_CTL_OVERFLOW_CLEAR]) begin
                overflow_count_reg <= `TTGIC_RESET_OVF; // RL2
            end
            if (ictl_wr) begin
                irq_level_reg <= wdata[`TTGIC_ICTL_LEVEL_MSB:`TTGIC_ICTL_LEVEL_LSB]; // RL13
                irq_enable_reg <= wdata[`TTGIC_ICTL_IRQ_ENABLE];
            end
            // set beats clear when both land together
            if (match && irq_enable_reg) begin
                irq_status_reg <= 1'b1; // RL15
            end else if (ictl_wr && wdata[`TTGIC_ICTL_IRQ_CLEAR]) begin
                irq_status_reg <= 1'b0; // RL14
            end
        end
    end

    // counter steering: advance once per microsecond tick while enabled
    assign count_advance = tick & count_enable_reg; // RL17
    assign count_clear = match & compare_clear_reg; // RL4

    // request leaves only when enabled and at a nonzero level
    assign irq_req = irq_status_reg & irq_enable_reg & (|irq_level_reg); // RL8
    assign irq_level = irq_level_reg;

    // strobe bits read back as zero
    assign ctl_rdata = {overflow_count_reg, 1'b0, 1'b0, compare_clear_reg, count_enable_reg}; // RL5
    assign ictl_rdata = {2'b00, irq_status_reg, irq_enable_reg, 1'b0, irq_level_reg}; // RL14

endmodule // ttgic_timer

`default_nettype wire

// [verilog/ttgic_top.v]
// tick timer control, timer interrupt control and gpio pin / interrupt control
//
// Overview of operation
// [RL1] overflow count increments on every timer interrupt
// [RL2] writing overflow clear zeroes the overflow count
// [RL3] counter advances only while count enable set
// [RL4] compare clear returns counter to zero on match
// [RL5] timer 1 control register mirrors timer 2 layout
// [RL6] gpio level field selects level; zero suppresses
// [RL7] gpio clear works in edge mode, reads zero
// [RL8] enable bits permit or block each interrupt
// [RL9] gpio status reads high while requesting
// [RL10] edge select latches; clear gives level sensitivity
// [RL11] polarity picks rising/high or falling/low
// [RL12] software clears gpio status when changing mode
// [RL13] timer interrupt level field; zero means none
// [RL14] timer clear bit clears status, reads zero
// [RL15] timer status latches on compare until cleared
// [RL16] compare match raises event and counts overflow
// [RL17] enabled counter advances once per microsecond
// [RL18] output enable drives output value, else floats
// [RL19] input bit returns synchronised pin level
`timescale 1ns/1ps
`default_nettype none
`include "ttgic_map.vh"

module ttgic_top (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // local bus register access, one byte per access
    input wire [31:0] reg_addr,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    // prescaler tick and comparator matches from the counter section
    input wire tick_1mhz,
    input wire t1_match,
    input wire t2_match,
    // counter steering to the counter section
    output wire t1_count_advance,
    output wire t1_count_clear,
    output wire t2_count_advance,
    output wire t2_count_clear,
    // interrupt requests to the local bus interrupter
    output wire t1_irq_req,
    output wire [2:0] t1_irq_level,
    output wire t2_irq_req,
    output wire [2:0] t2_irq_level,
    output wire gpio_irq_req,
    output wire [2:0] gpio_irq_level,
    // gpio pin, split into three signals
    input wire gpio_pin_in,
    output wire gpio_pin_out,
    output wire gpio_pin_oe_n
);

    // address decode
    wire sel_t2_ctl;
    wire sel_t1_ctl;
    wire sel_gpio_ictl;
    wire sel_gpio_pin;
    wire sel_t2_ictl;
    wire sel_t1_ictl;

    // write strobes
    wire wr_t2_ctl;
    wire wr_t1_ctl;
    wire wr_gpio_ictl;
    wire wr_gpio_pin;
    wire wr_t2_ictl;
    wire wr_t1_ictl;

    // timer read views
    wire [7:0] t1_ctl_rdata;
    wire [7:0] t1_ictl_rdata;
    wire [7:0] t2_ctl_rdata;
    wire [7:0] t2_ictl_rdata;

    // gpio interrupt control state
    reg [2:0] gpio_level_reg;
    reg gpio_enable_reg;
    reg gpio_edge_mode_reg;
    reg gpio_polarity_reg;
    reg gpio_latch_reg;

    // gpio pin control state
    reg pin_output_value_reg;
    reg pin_output_enable_reg;

    // pin synchroniser and edge history
    reg pin_sync1_reg;
    reg pin_sync2_reg;
    reg pin_prev_reg;

    // gpio trigger terms
    wire pin_active;
    wire pin_prev_active;
    wire pin_active_edge;
    wire gpio_int;
    wire gpio_clear;

    // read mux
    reg [7:0] rdata_next;

    // full-address decode against the register byte addresses
    assign sel_t2_ctl = (reg_addr == `TTGIC_ADDR_T2_CTL);
    assign sel_t1_ctl = (reg_addr == `TTGIC_ADDR_T1_CTL);
    assign sel_gpio_ictl = (reg_addr == `TTGIC_ADDR_GPIO_ICTL);
    assign sel_gpio_pin = (reg_addr == `TTGIC_ADDR_GPIO_PIN);
    assign sel_t2_ictl = (reg_addr == `TTGIC_ADDR_T2_ICTL);
    assign sel_t1_ictl = (reg_addr == `TTGIC_ADDR_T1_ICTL);

    // writes take effect on the edge that sees the strobe
    assign wr_t2_ctl = reg_wr_en & sel_t2_ctl;
    assign wr_t1_ctl = reg_wr_en & sel_t1_ctl;
    assign wr_gpio_ictl = reg_wr_en & sel_gpio_ictl;
    assign wr_gpio_pin = reg_wr_en & sel_gpio_pin;
    assign wr_t2_ictl = reg_wr_en & sel_t2_ictl;
    assign wr_t1_ictl = reg_wr_en & sel_t1_ictl;

    // tick timer 1: control at its own address, same layout as timer 2
    ttgic_timer u_timer1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctl_wr(wr_t1_ctl), // RL5
        .ictl_wr(wr_t1_ictl),
        .wdata(reg_wdata),
        .tick(tick_1mhz),
        .match(t1_match), // RL16
        .count_advance(t1_count_advance),
        .count_clear(t1_count_clear),
        .ctl_rdata(t1_ctl_rdata),
        .ictl_rdata(t1_ictl_rdata),
        .irq_req(t1_irq_req),
        .irq_level(t1_irq_level)
    );

    // tick timer 2
    ttgic_timer u_timer2 (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctl_wr(wr_t2_ctl),
        .ictl_wr(wr_t2_ictl),
        .wdata(reg_wdata),
        .tick(tick_1mhz),
        .match(t2_match), // RL16
        .count_advance(t2_count_advance),
        .count_clear(t2_count_clear),
        .ctl_rdata(t2_ctl_rdata),
        .ictl_rdata(t2_ictl_rdata),
        .irq_req(t2_irq_req),
        .irq_level(t2_irq_level)
    );

    // two-stage synchroniser; only the second stage feeds logic
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_sync1_reg <= gpio_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg <= pin_sync2_reg;
        end
    end

    // polarity folds into the trigger, so one detector serves both senses
    assign pin_active = pin_sync2_reg ^ gpio_polarity_reg; // RL11
    assign pin_prev_active = pin_prev_reg ^ gpio_polarity_reg;
    // both terms use the current polarity, so a polarity flip alone raises no edge
    assign pin_active_edge = pin_active & ~pin_prev_active; // RL12

    // clear strobe is honoured only in edge mode
    assign gpio_clear = wr_gpio_ictl & reg_wdata[`TTGIC_ICTL_IRQ_CLEAR] & gpio_edge_mode_reg; // RL7

    // gpio interrupt control register fields
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gpio_level_reg <= `TTGIC_RESET_LEVEL;
            gpio_enable_reg <= 1'b0;
            gpio_edge_mode_reg <= 1'b0;
            gpio_polarity_reg <= 1'b0;
        end else if (wr_gpio_ictl) begin
            gpio_level_reg <= reg_wdata[`TTGIC_ICTL_LEVEL_MSB:`TTGIC_ICTL_LEVEL_LSB]; // RL6
            gpio_enable_reg <= reg_wdata[`TTGIC_ICTL_IRQ_ENABLE]; // RL8
            gpio_edge_mode_reg <= reg_wdata[`TTGIC_ICTL_EDGE_MODE]; // RL10
            gpio_polarity_reg <= reg_wdata[`TTGIC_ICTL_POLARITY]; // RL11
        end
    end

    // edge latch: set wins over a clear in the same cycle
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gpio_latch_reg <= 1'b0;
        end else if (gpio_edge_mode_reg && gpio_enable_reg && pin_active_edge) begin
            gpio_latch_reg <= 1'b1; // RL10
        end else if (gpio_clear) begin
            gpio_latch_reg <= 1'b0; // RL7
        end else if (!gpio_edge_mode_reg) begin
            // level mode keeps no memory, so a stale latch cannot resurface
            gpio_latch_reg <= 1'b0;
        end
    end

    // level mode follows the pin live; edge mode shows the latch
    assign gpio_int = gpio_edge_mode_reg ? (gpio_latch_reg & gpio_enable_reg)
                                         : (pin_active & gpio_enable_reg); // RL10
    assign gpio_irq_req = gpio_int & (|gpio_level_reg); // RL6
    assign gpio_irq_level = gpio_level_reg;

    // gpio pin control register
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_output_value_reg <= 1'b0;
            pin_output_enable_reg <= 1'b0;
        end else if (wr_gpio_pin) begin
            pin_output_value_reg <= reg_wdata[`TTGIC_PIN_OUTPUT_VALUE];
            pin_output_enable_reg <= reg_wdata[`TTGIC_PIN_OUTPUT_ENABLE];
        end
    end

    // pin drive: enable low means driving, high leaves the pin floating
    assign gpio_pin_out = pin_output_value_reg; // RL18
    assign gpio_pin_oe_n = ~pin_output_enable_reg; // RL18

    // read mux; strobe bits and unused bits read zero
    always @* begin
        rdata_next = `TTGIC_RESET_BYTE;
        if (sel_t2_ctl) begin
            rdata_next = t2_ctl_rdata;
        end else if (sel_t1_ctl) begin
            rdata_next = t1_ctl_rdata; // RL5
        end else if (sel_gpio_ictl) begin
            rdata_next[`TTGIC_ICTL_LEVEL_MSB:`TTGIC_ICTL_LEVEL_LSB] = gpio_level_reg;
            rdata_next[`TTGIC_ICTL_IRQ_ENABLE] = gpio_enable_reg;
            rdata_next[`TTGIC_ICTL_STATUS] = gpio_int & (|gpio_level_reg); // RL9
            rdata_next[`TTGIC_ICTL_EDGE_MODE] = gpio_edge_mode_reg;
            rdata_next[`TTGIC_ICTL_POLARITY] = gpio_polarity_reg;
        end else if (sel_gpio_pin) begin
            rdata_next[`TTGIC_PIN_OUTPUT_VALUE] = pin_output_value_reg;
            rdata_next[`TTGIC_PIN_OUTPUT_ENABLE] = pin_output_enable_reg;
            rdata_next[`TTGIC_PIN_INPUT_VALUE] = pin_sync2_reg; // RL19
        end else if (sel_t2_ictl) begin
            rdata_next = t2_ictl_rdata;
        end else if (sel_t1_ictl) begin
            rdata_next = t1_ictl_rdata;
        end
    end

    // bus answer one cycle after any strobe, mapped or not
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= `TTGIC_RESET_BYTE;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_wr_en | reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rdata_next;
            end
        end
    end

endmodule // ttgic_top

`default_nettype wire

// [verification/ttgic_cnt_model.sv]
// counter section model: prescaler tick, two up-counters, compare events
`timescale 1ns/1ps
`default_nettype none
module ttgic_cnt_model #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // compare values from the bench, steering from the block
    input wire logic [1:0][31:0] cmp,
    input wire logic [1:0] adv,
    input wire logic [1:0] clr,
    // tick and compare events to the block
    output logic tick_1mhz,
    output logic [1:0] match
);
    int div;
    logic [1:0][31:0] cnt;
    // short tick period keeps the run brief; the block never counts cycles itself
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div <= 0;
            tick_1mhz <= 1'b0;
            cnt <= 64'h0;
            match <= 2'h0;
        end else begin
            div <= (div == TICK_DIV - 1) ? 0 : div + 1;
            tick_1mhz <= (div == TICK_DIV - 1);
            for (int i = 0; i < 2; i++) begin
                if (clr[i]) begin
                    cnt[i] <= 32'h0;
                end else if (adv[i]) begin
                    cnt[i] <= cnt[i] + 32'h1;
                end
                // event once, as the count reaches the compare value
                match[i] <= !clr[i] && adv[i] && (cnt[i] + 32'h1 == cmp[i]);
            end
        end
    end
endmodule // ttgic_cnt_model
`default_nettype wire

// [verification/ttgic_top_chk.sv]
// port assertions for the tick timer / gpio control block
`timescale 1ns/1ps
`default_nettype none
`include "ttgic_map.vh"
module ttgic_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic reg_ack,
    // counter section
    input wire logic tick_1mhz,
    input wire logic t1_match,
    input wire logic t2_match,
    input wire logic t1_count_advance,
    input wire logic t2_count_advance,
    input wire logic t1_count_clear,
    input wire logic t2_count_clear,
    // interrupts
    input wire logic t1_irq_req,
    input wire logic [2:0] t1_irq_level,
    input wire logic gpio_irq_req,
    input wire logic [2:0] gpio_irq_level
);
    logic t1_wr;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    // only a write to its own register or a timer 1 match may change timer 1 interrupt state
    assign t1_wr = reg_wr_en && reg_addr == `TTGIC_ADDR_T1_ICTL;
    sequence s_strobe;
        reg_wr_en || reg_rd_en;
    endsequence
    sequence s_ack_next;
        ##1 reg_ack;
    endsequence
    property p_ack; s_strobe |-> s_ack_next; endproperty
    a_ack: assert property (p_ack) else $error("ack missing after strobe");
    property p_noack; !reg_wr_en && !reg_rd_en |=> !reg_ack; endproperty
    a_noack: assert property (p_noack) else $error("ack without strobe");
    property p_adv1; t1_count_advance |-> tick_1mhz; endproperty
    a_adv1: assert property (p_adv1) else $error("timer 1 advance without tick");
    property p_adv2; t2_count_advance |-> tick_1mhz; endproperty
    a_adv2: assert property (p_adv2) else $error("timer 2 advance without tick");
    property p_clr1; t1_count_clear |-> t1_match; endproperty
    a_clr1: assert property (p_clr1) else $error("timer 1 clear without match");
    property p_clr2; t2_count_clear |-> t2_match; endproperty
    a_clr2: assert property (p_clr2) else $error("timer 2 clear without match");
    property p_lvl1; t1_irq_level == 3'h0 |-> !t1_irq_req; endproperty
    a_lvl1: assert property (p_lvl1) else $error("timer 1 request at level 0");
    property p_glvl; gpio_irq_level == 3'h0 |-> !gpio_irq_req; endproperty
    a_glvl: assert property (p_glvl) else $error("gpio request at level 0");
    property p_hold; t1_irq_req && !t1_wr |=> t1_irq_req; endproperty
    a_hold: assert property (p_hold) else $error("timer 1 request dropped");
    property p_quiet; !t1_irq_req && !t1_match && !t1_wr |=> !t1_irq_req; endproperty
    a_quiet: assert property (p_quiet) else $error("timer 1 request uncaused");
    property p_lstable; !t1_wr |=> $stable(t1_irq_level); endproperty
    a_lstable: assert property (p_lstable) else $error("timer 1 level moved");
endmodule // ttgic_chk
bind ttgic_top ttgic_chk u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_ack(reg_ack), .tick_1mhz(tick_1mhz),
    .t1_match(t1_match), .t2_match(t2_match), .t1_count_advance(t1_count_advance),
    .t2_count_advance(t2_count_advance), .t1_count_clear(t1_count_clear),
    .t2_count_clear(t2_count_clear), .t1_irq_req(t1_irq_req), .t1_irq_level(t1_irq_level),
    .gpio_irq_req(gpio_irq_req), .gpio_irq_level(gpio_irq_level));
`default_nettype wire

// [verification/ttgic_top_tb.sv]
// self-checking bench for the tick timer / gpio control block
`timescale 1ns/1ps
`default_nettype none
`include "ttgic_map.vh"
module ttgic_top_tb;
    logic clk_sys, rst, reg_wr_en, reg_rd_en, reg_ack, tick_1mhz, gpio_pin_in;
    logic [31:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_v;
    logic [1:0] match, adv, clr, irq;
    logic [1:0][31:0] cmp;
    logic [2:0] lvl1, lvl2, glvl;
    logic greq, pin_out, pin_oe_n;
    int n_fail, comparisons, cycles, n_ev;
    int exp_ovf [2];
    int exp_st [2];
    logic [31:0] ctl_a [2] = '{`TTGIC_ADDR_T1_CTL, `TTGIC_ADDR_T2_CTL};
    logic [31:0] ictl_a [2] = '{`TTGIC_ADDR_T1_ICTL, `TTGIC_ADDR_T2_ICTL};
    logic [7:0] g_ctl [11] = '{8'h11, 8'h19, 8'h11, 8'h91, 8'h90, 8'h59, 8'h51, 8'h59,
        8'hD9, 8'hD1, 8'hD9};
    logic [0:10] g_pin = 11'b11000011100;
    logic [0:10] g_st = 11'b11010010010;
    ttgic_top DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .tick_1mhz(tick_1mhz), .t1_match(match[0]), .t2_match(match[1]),
        .t1_count_advance(adv[0]), .t1_count_clear(clr[0]), .t2_count_advance(adv[1]),
        .t2_count_clear(clr[1]), .t1_irq_req(irq[0]), .t1_irq_level(lvl1), .t2_irq_req(irq[1]),
        .t2_irq_level(lvl2), .gpio_irq_req(greq), .gpio_irq_level(glvl),
        .gpio_pin_in(gpio_pin_in), .gpio_pin_out(pin_out), .gpio_pin_oe_n(pin_oe_n));
    ttgic_cnt_model u_cnt (.clk_sys(clk_sys), .rst(rst), .cmp(cmp), .adv(adv), .clr(clr),
        .tick_1mhz(tick_1mhz), .match(match));
    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // reference model: every event bumps the count, only timer 1 has its request enabled
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict;
        end
        for (int i = 0; i < 2; i++) begin
            if (match[i] === 1'b1) begin
                exp_ovf[i] = (exp_ovf[i] + 1) % 16;
                exp_st[i] = (i == 0);
                // raw timer 1 event count, no wrap, shows the clear-on-compare repeats
                n_ev += (i == 0);
            end
        end
    end
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    // one-cycle strobe; ack and read data land one cycle later
    task automatic acc(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        #1 rd_v = reg_rdata;
        chk_bit("ack", 1'b1, reg_ack);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(9));
        {rst, reg_wr_en, reg_rd_en, gpio_pin_in} = 4'h8;
        reg_addr = 32'h0;
        reg_wdata = 8'h00;
        cmp = 64'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, last address unmapped
        for (int i = 0; i < 7; i++) begin
            acc(1'b0, 32'hFFF42016 + i, 8'h00);
            chk_reg("reset value", 8'h00, rd_v);
        end
        // timer 1 clears on compare with request on, timer 2 runs on with request off
        for (int t = 0; t < 2; t++) begin
            cmp[t] <= 32'h3 + ($urandom % 4);
            acc(1'b1, ictl_a[t], t ? 8'h03 : 8'h13);
            acc(1'b1, ctl_a[t], t ? 8'h01 : 8'h03);
        end
        repeat (200) @(posedge clk_sys);
        for (int t = 0; t < 2; t++) acc(1'b1, ctl_a[t], 8'h00);
        // both counters disabled: no advance may leave the block
        repeat (8) begin
            @(posedge clk_sys);
            #1 chk_bit("count stopped", 1'b0, adv[0] | adv[1]);
        end
        chk_reg("timer 2 events", 8'h01, 8'(exp_ovf[1]));
        chk_bit("timer1 request", 1'(exp_st[0]), irq[0]);
        chk_bit("timer2 request", 1'b0, irq[1]);
        chk_reg("timer1 level", 8'h03, 8'(lvl1));
        chk_reg("timer2 level", 8'h03, 8'(lvl2));
        chk_bit("timer1 periodic", 1'b1, 1'(n_ev > 1));
        for (int t = 0; t < 2; t++) begin
            acc(1'b0, ctl_a[t], 8'h00);
            chk_reg("overflow count", 8'(exp_ovf[t] << 4), rd_v);
            acc(1'b0, ictl_a[t], 8'h00);
            chk_reg("timer status", (t ? 8'h03 : 8'h13) | 8'(exp_st[t] << 5), rd_v);
            acc(1'b1, ctl_a[t], 8'h04);
            acc(1'b0, ctl_a[t], 8'h00);
            chk_reg("overflow cleared", 8'h00, rd_v);
            acc(1'b1, ictl_a[t], t ? 8'h0B : 8'h1B);
            acc(1'b0, ictl_a[t], 8'h00);
            chk_reg("status cleared", t ? 8'h03 : 8'h13, rd_v);
        end
        chk_bit("timer1 request", 1'b0, irq[0]);
        // gpio modes, polarities, level zero and clears from the table
        for (int k = 0; k < 11; k++) begin
            acc(1'b1, `TTGIC_ADDR_GPIO_ICTL, g_ctl[k]);
            @(posedge clk_sys);
            gpio_pin_in <= g_pin[k];
            repeat (6) @(posedge clk_sys);
            acc(1'b0, `TTGIC_ADDR_GPIO_ICTL, 8'h00);
            chk_reg("gpio status", (g_ctl[k] & 8'hF7) | {2'h0, g_st[k], 5'h0}, rd_v);
            chk_bit("gpio request", g_st[k], greq);
            chk_reg("gpio level", {5'h0, g_ctl[k][2:0]}, {5'h0, glvl});
        end
        // pin drive and readback with a random pin level
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            gpio_pin_in <= 1'($urandom);
            acc(1'b1, `TTGIC_ADDR_GPIO_PIN, 8'(k));
            repeat (4) @(posedge clk_sys);
            acc(1'b0, `TTGIC_ADDR_GPIO_PIN, 8'h00);
            chk_reg("pin control", 8'(k) | {5'h0, gpio_pin_in, 2'h0}, rd_v);
            chk_bit("pin float", !k[1], pin_oe_n);
            if (k[1]) chk_bit("pin level", k[0], pin_out);
        end
        give_verdict;
    end
endmodule // ttgic_top_tb
`default_nettype wire
